// File: hw/serial_dac_map.vh
`ifndef SERIAL_DAC_MAP_VH
`define SERIAL_DAC_MAP_VH

// Frame and code geometry
`define CODE_WIDTH       8
`define BITS_PER_FRAME   4'h8
`define BIT_CNT_RESET    4'h0
`define CODE_RESET       8'h00
`define FIFO_DEPTH       8
`define FIFO_PTR_WIDTH   3
`define FIFO_CNT_WIDTH   4

// Serial clock limit, in MHz, against the 20 MHz ref_clk
`define SCLK_MAX_MHZ     50
`define REF_CLK_MHZ      20

`endif

// File: hw/code_fifo.v
// The code buffer module is kept together with the serial port logic.

// File: hw/serial_dac_input_port.v
`timescale 1ns/1ns
`include "serial_dac_map.vh"

module serial_dac_input_port (
  input  wire                   ref_clk,
  input  wire                   reset_n,
  input  wire                   serial_clk,
  input  wire                   frame_sync_n,
  input  wire                   serial_data_in,
  input  wire                   output_load_strobe_n,
  output reg  [`CODE_WIDTH-1:0] dac_code_r,
  output reg                    dac_update_r,
  output reg                    frame_overrun_r
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Falling edge from the previous and present synchronised levels
  function edge_fell;
    input prev_level;
    input cur_level;
    begin
      edge_fell = prev_level & ~cur_level;
    end
  endfunction

  // Shift one bit in at the bottom, so the first bit ends at the top
  function [`CODE_WIDTH-1:0] shift_in;
    input [`CODE_WIDTH-1:0] cur;
    input                   bit_in;
    begin
      shift_in = {cur[`CODE_WIDTH-2:0], bit_in};
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are oversampled by ref_clk; serial clock edges must be slow
  // enough to be seen, so the usable rate is well under the pin limit.
  reg [1:0] sclk_sync_r;
  reg [1:0] sync_sync_r;
  reg [1:0] data_sync_r;
  reg [1:0] load_sync_r;
  reg       sclk_prev_r;
  reg       load_prev_r;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sync_r <= 2'b11;
      sync_sync_r <= 2'b11;
      data_sync_r <= 2'b00;
      load_sync_r <= 2'b11;
      sclk_prev_r <= 1'b1;
      load_prev_r <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], serial_clk};
      sync_sync_r <= {sync_sync_r[0], frame_sync_n};
      data_sync_r <= {data_sync_r[0], serial_data_in};
      load_sync_r <= {load_sync_r[0], output_load_strobe_n};
      sclk_prev_r <= sclk_sync_r[1];
      load_prev_r <= load_sync_r[1];
    end
  end

  wire sclk_fall  = edge_fell(sclk_prev_r, sclk_sync_r[1]);
  wire frame_on   = ~sync_sync_r[1];
  wire load_fall  = edge_fell(load_prev_r, load_sync_r[1]);
  wire load_low   = ~load_sync_r[1];

  // ----------------------------------------------------------------
  // Shift register and frame state
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE  = 3'b100;

  reg [2:0]             state_r;
  reg [3:0]             bit_cnt_r;
  reg [`CODE_WIDTH-1:0] shift_r;
  reg [`CODE_WIDTH-1:0] input_reg_r;
  reg                   push_r;
  wire                  fifo_in_ready;
  wire [`CODE_WIDTH-1:0] fifo_out_data;
  wire                  fifo_out_valid;
  reg                   fifo_pop;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r         <= ST_IDLE;
      bit_cnt_r       <= `BIT_CNT_RESET;
      shift_r         <= `CODE_RESET;
      input_reg_r     <= `CODE_RESET;
      push_r          <= 1'b0;
      frame_overrun_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          bit_cnt_r <= `BIT_CNT_RESET;
          if (frame_on) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!frame_on) begin
            state_r <= ST_IDLE;  // Short frame is dropped
          end else if (sclk_fall) begin
            shift_r   <= shift_in(shift_r, data_sync_r[1]);
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == `BITS_PER_FRAME - 4'h1) begin
              input_reg_r <= shift_in(shift_r, data_sync_r[1]);
              push_r      <= 1'b1;
              state_r     <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          if (!frame_on) begin
            state_r <= ST_IDLE;
          end else if (sclk_fall) begin
            frame_overrun_r <= 1'b1; // Extra edges set the sticky overrun flag
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Code buffer and output latch
  // ----------------------------------------------------------------
  // Auto mode queues completed codes; strobe mode latches the newest code.
  code_fifo #(
    .WIDTH (`CODE_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .PTR_W (`FIFO_PTR_WIDTH),
    .CNT_W (`FIFO_CNT_WIDTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_data   (input_reg_r),
    .in_valid  (push_r & load_low),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  reg pace_r;

  always @* begin
    fifo_pop = fifo_out_valid & load_low & ~pace_r;
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_code_r   <= `CODE_RESET;
      dac_update_r <= 1'b0;
      pace_r       <= 1'b0;
    end else begin
      dac_update_r <= 1'b0;
      pace_r       <= fifo_pop;
      if (load_fall) begin
        dac_code_r   <= input_reg_r;
        dac_update_r <= 1'b1;
      end else if (fifo_pop) begin
        dac_code_r   <= fifo_out_data;
        dac_update_r <= 1'b1;
      end
    end
  end

  wire unused_ready = fifo_in_ready;

endmodule

// ----------------------------------------------------------------
// Code buffer between the shift register and the output latch
// ----------------------------------------------------------------
module code_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter PTR_W = 3,
  parameter CNT_W = 4
) (
  input  wire             ref_clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_r;
  reg [PTR_W-1:0] rd_ptr_r;
  reg [CNT_W-1:0] count_r;
  wire            push;
  wire            pop;

  assign in_ready  = (count_r != DEPTH[CNT_W-1:0]);
  assign out_valid = (count_r != {CNT_W{1'b0}});
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= {PTR_W{1'b0}};
      rd_ptr_r <= {PTR_W{1'b0}};
      count_r  <= {CNT_W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// File: dv/host_model.sv
`timescale 1ns/1ns
// ----
// Host serial port
// ----
module host_model (
  input  wire ref_clk,
  output reg  serial_clk,
  output reg  frame_sync_n,
  output reg  serial_data_in
);
  integer i;
  initial begin
    serial_clk = 1'b1;
    frame_sync_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task step(input integer k);
    begin
      repeat (k) @(posedge ref_clk);
      #5;
    end
  endtask
  // Clock phases of four cycles stay under the rate limit
  task send(input [7:0] code, input integer n);
    begin
      step(1);
      frame_sync_n = 1'b0;
      step(3);
      for (i = 0; i < n; i = i + 1) begin
        serial_data_in = code[7 - (i % 8)];
        step(3);
        serial_clk = 1'b0;
        step(4);
        serial_clk = 1'b1;
        step(1);
      end
      step(2);
      frame_sync_n = 1'b1;
      serial_data_in = ~serial_data_in;
      step(6);
    end
  endtask
endmodule

// File: dv/serial_dac_input_port_chk.sv
`timescale 1ns/1ns
`include "serial_dac_map.vh"
// ----
// Port checker
// ----
module serial_dac_input_port_chk (
  input wire                   ref_clk,
  input wire                   reset_n,
  input wire                   serial_clk,
  input wire                   frame_sync_n,
  input wire                   serial_data_in,
  input wire                   output_load_strobe_n,
  input wire [`CODE_WIDTH-1:0] dac_code_r,
  input wire                   dac_update_r,
  input wire                   frame_overrun_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_pulse_one: assert property (dac_update_r |=> !dac_update_r)
    else $error("update pulse too long");
  chk_code_load: assert property (!$stable(dac_code_r) |-> dac_update_r)
    else $error("code changed without update");
  chk_strobe_load: assert property ($fell(output_load_strobe_n) |-> ##[1:6] dac_update_r)
    else $error("strobe fall gave no update");
  chk_update_cause: assert property (dac_update_r |-> !$past(output_load_strobe_n, 3))
    else $error("update without strobe low");
  chk_strobe_idle: assert property (output_load_strobe_n [*8] |-> !dac_update_r)
    else $error("update while strobe high");
  chk_over_sticky: assert property (frame_overrun_r |=> frame_overrun_r)
    else $error("overrun flag dropped");
endmodule
bind serial_dac_input_port serial_dac_input_port_chk serial_dac_input_port_chk_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
  .serial_data_in(serial_data_in), .output_load_strobe_n(output_load_strobe_n),
  .dac_code_r(dac_code_r), .dac_update_r(dac_update_r), .frame_overrun_r(frame_overrun_r));

// File: dv/serial_dac_input_port_tb.sv
`timescale 1ns/1ns
`include "serial_dac_map.vh"
// ----
// Bench
// ----
module serial_dac_input_port_tb;
  reg                    ref_clk;
  reg                    reset_n;
  reg                    strobe_n;
  wire                   sclk;
  wire                   sync_n;
  wire                   sdata;
  wire [`CODE_WIDTH-1:0] code;
  wire                   upd;
  wire                   over;
  integer                fail_count;
  integer                num_checks;
  integer                n;
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  host_model host_model_i (.ref_clk(ref_clk), .serial_clk(sclk), .frame_sync_n(sync_n), .serial_data_in(sdata));
  serial_dac_input_port serial_dac_input_port_i (.ref_clk(ref_clk), .reset_n(reset_n), .serial_clk(sclk),
    .frame_sync_n(sync_n), .serial_data_in(sdata), .output_load_strobe_n(strobe_n),
    .dac_code_r(code), .dac_update_r(upd), .frame_overrun_r(over));
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task check(input [95:0] what, input [7:0] exp, input [7:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Counts update pulses over a fixed span
  task count_upd(input integer k);
    begin
      n = 0;
      repeat (k) begin
        @(posedge ref_clk);
        #5;
        if (upd === 1'b1) n = n + 1;
      end
    end
  endtask
  task t_strobe;
    begin
      check("over_rst", 8'h00, {7'h00, over});
      fork
        host_model_i.send(8'hA5, 8);
        count_upd(85);
      join
      check("early_upd", 8'h00, n[7:0]);
      strobe_n = 1'b0;
      count_upd(8);
      strobe_n = 1'b1;
      check("strobe_upd", 8'h01, n[7:0]);
      check("code", 8'hA5, code);
      $display("test strobe done");
    end
  endtask
  task t_auto;
    begin
      count_upd(4);
      strobe_n = 1'b0;
      count_upd(10);
      check("relatch_upd", 8'h01, n[7:0]);
      check("relatch_code", 8'hA5, code);
      fork
        host_model_i.send(8'h3C, 8);
        count_upd(80);
      join
      check("auto_upd", 8'h01, n[7:0]);
      check("auto_code", 8'h3C, code);
      host_model_i.send(8'h81, 8);
      count_upd(6);
      check("auto_code2", 8'h81, code);
      fork
        host_model_i.send(8'hFF, 5);
        count_upd(60);
      join
      check("short_upd", 8'h00, n[7:0]);
      check("short_code", 8'h81, code);
      $display("test auto done");
    end
  endtask
  task t_over;
    begin
      host_model_i.send(8'h0F, 9);
      count_upd(10);
      check("over_set", 8'h01, {7'h00, over});
      check("over_code", 8'h0F, code);
      $display("test overrun done");
    end
  endtask
  initial begin
    reset_n = 1'b0;
    strobe_n = 1'b1;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(posedge ref_clk);
    #5;
    reset_n = 1'b1;
    t_strobe;
    t_auto;
    t_over;
    final_report;
  end
endmodule
